// >>> src/icwdt_defines.svh
// Constants for the instruction clock watchdog.
// Assumes inclusion by the package and the watchdog module only.
// Operation
// - Reload all ones, count down per instruction
// - Underflow from zero sets warning flag
// - Underflow with warning set raises fault
// - Fault drives reset pin low
// - Enable flag one makes reset active
// - Disable then restart clears enable flag
// - Enable set on reset and backup
// - Restart with warning clears and skips
// - Restart without warning does not skip
// - Skip works while watchdog disabled
// - Disable alone keeps watchdog running
// - Power-down reinitialises warning and counter
// - Watchdog active after power-down return
`ifndef ICWDT_DEFINES_SVH
`define ICWDT_DEFINES_SVH

`define ICWDT_CNT_W      16
`define ICWDT_CNT_INIT   16'hFFFF
`define ICWDT_CNT_ZERO   16'h0000
`define ICWDT_CNT_ONE    16'h0001
`define ICWDT_FLAG_RST   1'b0
`define ICWDT_EN_RST     1'b1

`endif

// >>> src/icwdt_pkg.sv
// Types for the instruction clock watchdog.
// Assumes the defines header sits beside it.
`include "icwdt_defines.svh"

package icwdt_pkg;

  // Arming state of the disable-then-restart sequence
  typedef enum logic [1:0] {
    ICWDT_IDLE  = 2'b01,
    ICWDT_ARMED = 2'b10
  } icwdt_seq_t;

endpackage

// >>> src/icwdt_watchdog.sv
// Instruction clock watchdog with flags, enable and skip.
// Assumes one pulse per executed instruction on instr_tick, and that
// the instruction strobes are valid only together with instr_tick.
`timescale 1ns/1ps
`include "icwdt_defines.svh"

module icwdt_watchdog
  import icwdt_pkg::*;
#(
  parameter int CNT_W = `ICWDT_CNT_W
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             instr_tick,
  input  wire logic             wd_restart_instr,
  input  wire logic             wd_disable_instr,
  input  wire logic             power_down_instr,
  input  wire logic             backup_entry,
  output logic                  skip_next,
  output logic                  wd_reset,
  output logic                  reset_pin_out,
  output logic                  reset_pin_oe,
  output logic                  wd_enable_flag,
  output logic                  wd_warning_flag,
  output logic                  wd_fault_flag,
  output logic [CNT_W-1:0]      wd_down_counter
);

  // ----------------------------------------------------------------
  // Check defaults
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_reg;
  logic             warn_reg;
  logic             fault_reg;
  logic             en_reg;
  logic             skip_reg;
  icwdt_seq_t       seq_reg;

  logic [CNT_W-1:0] cnt_next;
  logic             warn_next;
  logic             fault_next;
  logic             en_next;
  icwdt_seq_t       seq_next;

  // Instruction strobe qualified by the count pulse
  function automatic logic icwdt_op_taken(input logic tick, input logic strobe);
    return tick & strobe;
  endfunction

  wire restart   = icwdt_op_taken(instr_tick, wd_restart_instr);
  wire disable_i = icwdt_op_taken(instr_tick, wd_disable_instr);
  wire pdown     = icwdt_op_taken(instr_tick, power_down_instr);
  wire at_zero   = (cnt_reg == CNT_W'(`ICWDT_CNT_ZERO));
  wire underflow = instr_tick & at_zero & ~pdown;
  wire fault_hit = underflow & warn_reg & en_reg;
  wire seq_done  = restart & (seq_reg == ICWDT_ARMED);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next   = cnt_reg;
    warn_next  = warn_reg;
    fault_next = fault_reg | fault_hit;
    en_next    = en_reg;
    seq_next   = seq_reg;
    if (instr_tick) begin
      cnt_next = cnt_reg - CNT_W'(`ICWDT_CNT_ONE);
    end
    if (restart) begin
      warn_next = 1'b0;
    end
    if (underflow) begin
      warn_next = 1'b1;
    end
    if (pdown) begin
      cnt_next  = CNT_W'(`ICWDT_CNT_INIT);
      warn_next = 1'b0;
    end
    if (seq_done) begin
      en_next = 1'b0;
    end
    if (pdown) begin
      en_next = `ICWDT_EN_RST;
    end
    if (backup_entry) begin
      en_next = `ICWDT_EN_RST;
    end
    if (instr_tick) begin
      case (seq_reg)
        ICWDT_IDLE:  seq_next = disable_i ? ICWDT_ARMED : ICWDT_IDLE;
        ICWDT_ARMED: seq_next = disable_i ? ICWDT_ARMED : ICWDT_IDLE;
        default:     seq_next = ICWDT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // enable set at reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg   <= CNT_W'(`ICWDT_CNT_INIT);
      warn_reg  <= `ICWDT_FLAG_RST;
      fault_reg <= `ICWDT_FLAG_RST;
      en_reg    <= `ICWDT_EN_RST;
      seq_reg   <= ICWDT_IDLE;
    end else begin
      cnt_reg   <= cnt_next;
      warn_reg  <= warn_next;
      fault_reg <= fault_next;
      en_reg    <= en_next;
      seq_reg   <= seq_next;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      skip_reg <= 1'b0;
    end else begin
      skip_reg <= restart & warn_reg;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // open-drain pull-down
  assign reset_pin_out   = 1'b0;
  assign reset_pin_oe    = fault_reg;
  assign wd_reset        = fault_reg;
  assign skip_next       = skip_reg;
  assign wd_enable_flag  = en_reg;
  assign wd_warning_flag = warn_reg;
  assign wd_fault_flag   = fault_reg;
  assign wd_down_counter = cnt_reg;

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  logic chk_prev_dis_reg;
  logic chk_prev_dis_next;

  assign chk_prev_dis_next = instr_tick ? wd_disable_instr : chk_prev_dis_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      chk_prev_dis_reg <= `ICWDT_FLAG_RST;
    end else begin
      chk_prev_dis_reg <= chk_prev_dis_next;
    end
  end

  sequence s_disable;
    instr_tick && wd_disable_instr && !backup_entry;
  endsequence
  sequence s_restart;
    instr_tick && wd_restart_instr && !backup_entry;
  endsequence
  sequence s_plain;
    instr_tick && !wd_restart_instr && !wd_disable_instr && !power_down_instr;
  endsequence
  sequence s_underflow;
    instr_tick && at_zero && !power_down_instr;
  endsequence
  sequence s_pdown;
    instr_tick && power_down_instr;
  endsequence

  // ----------------------------------------------------------------
  // Counter checks
  // ----------------------------------------------------------------
  a_count_down: assert property (
    instr_tick && !power_down_instr |=> cnt_reg == $past(cnt_reg) - CNT_W'(`ICWDT_CNT_ONE))
    else $error("counter did not decrement");
  a_count_hold: assert property (
    !instr_tick |=> $stable(cnt_reg))
    else $error("counter moved without a tick");
  a_count_wrap: assert property (
    s_underflow |=> cnt_reg == CNT_W'(`ICWDT_CNT_INIT))
    else $error("counter did not reload on underflow");
  a_pdown_init: assert property (
    s_pdown |=> cnt_reg == CNT_W'(`ICWDT_CNT_INIT) && !warn_reg)
    else $error("power-down did not reinitialise");

  // ----------------------------------------------------------------
  // Flag checks
  // ----------------------------------------------------------------
  a_warn_set: assert property (
    s_underflow |=> warn_reg)
    else $error("underflow did not set warning");
  a_warn_hold: assert property (
    !instr_tick |=> $stable(warn_reg))
    else $error("warning moved without a tick");
  a_warn_keep: assert property (
    warn_reg && !(instr_tick && (wd_restart_instr || power_down_instr)) |=> warn_reg)
    else $error("warning cleared without restart");
  a_warn_clear: assert property (
    s_restart ##0 !at_zero |=> !warn_reg)
    else $error("restart did not clear warning");
  a_fault_set: assert property (
    s_underflow ##0 (warn_reg && en_reg) |=> wd_reset)
    else $error("second underflow did not raise fault");
  a_fault_hold: assert property (
    wd_reset |=> wd_reset)
    else $error("fault dropped before reset");
  a_fault_cause: assert property (
    !wd_reset && !(instr_tick && at_zero && warn_reg) |=> !wd_reset)
    else $error("fault raised without second underflow");
  a_no_fault_off: assert property (
    !en_reg && !fault_reg |=> !fault_reg)
    else $error("fault raised while disabled");
  a_pdown_keep: assert property (
    s_pdown ##0 !wd_reset |=> !wd_reset)
    else $error("power-down raised fault");

  // ----------------------------------------------------------------
  // Reset pin checks
  // ----------------------------------------------------------------
  a_pin_low: assert property (
    wd_reset |-> reset_pin_oe && !reset_pin_out)
    else $error("reset pin not pulled low");
  a_pin_idle: assert property (
    !wd_reset |-> !reset_pin_oe)
    else $error("reset pin driven without fault");

  // ----------------------------------------------------------------
  // Enable checks
  // ----------------------------------------------------------------
  a_seq_clear: assert property (
    s_restart ##0 chk_prev_dis_reg |=> !en_reg)
    else $error("disable sequence did not clear enable");
  a_seq_gap: assert property (
    s_disable ##1 !instr_tick ##1 s_restart |=> !en_reg)
    else $error("spaced disable sequence did not clear enable");
  a_backup_en: assert property (
    backup_entry |=> en_reg)
    else $error("backup did not set enable");
  a_en_hold: assert property (
    !en_reg && !backup_entry && !(instr_tick && power_down_instr) |=> !en_reg)
    else $error("enable set without cause");
  a_disable_only: assert property (
    en_reg && instr_tick && !wd_restart_instr && !backup_entry |=> en_reg)
    else $error("enable dropped without restart");
  a_dis_keep: assert property (
    s_disable ##0 en_reg |=> en_reg)
    else $error("disable alone dropped enable");
  a_pdown_en: assert property (
    s_pdown |=> en_reg)
    else $error("watchdog not active after power-down");
  a_seq_broken: assert property (
    s_disable ##1 !instr_tick ##1 s_plain ##1 !instr_tick ##1 s_restart ##0 en_reg
      |=> en_reg)
    else $error("broken sequence cleared enable");
  a_seq_stale: assert property (
    s_restart ##0 !chk_prev_dis_reg ##0 en_reg |=> en_reg)
    else $error("stale disable cleared enable");
  a_seq_onehot: assert property (
    $onehot(seq_reg))
    else $error("sequence state not one-hot");

  // ----------------------------------------------------------------
  // Skip checks
  // ----------------------------------------------------------------
  a_skip_warn: assert property (
    instr_tick && wd_restart_instr && warn_reg |=> skip_next)
    else $error("restart with warning did not skip");
  a_no_skip: assert property (
    instr_tick && wd_restart_instr && !warn_reg |=> !skip_next)
    else $error("restart without warning skipped");
  a_skip_one: assert property (
    !(instr_tick && wd_restart_instr) |=> !skip_next)
    else $error("skip without restart");
  a_skip_dis: assert property (
    !en_reg && instr_tick && wd_restart_instr && warn_reg |=> skip_next)
    else $error("skip lost while disabled");
  a_skip_dis_no: assert property (
    s_restart ##0 (!en_reg && !warn_reg) |=> !skip_next)
    else $error("skip while disabled without warning");

endmodule

// >>> tb/icwdt_cpu_model.sv
// CPU core stand-in: instruction strobes and reset pin loop.
// Assumes the bench drives go and op on rising core_clk.
`timescale 1ns/1ps

module icwdt_cpu_model (
  input  wire logic       core_clk,
  input  wire logic       bench_rst_n,
  input  wire logic       go,
  input  wire logic [1:0] op,
  input  wire logic       reset_pin_out,
  input  wire logic       reset_pin_oe,
  output logic            instr_tick,
  output logic            wd_restart_instr,
  output logic            wd_disable_instr,
  output logic            power_down_instr,
  output logic            reset_pin,
  output logic            nrst
);
  // ----------------------------------------
  // Strobes and reset loop
  // ----------------------------------------
  logic pin_reg;

  // Strobes follow op even without a tick
  assign instr_tick       = go;
  assign wd_restart_instr = (op == 2'h1);
  assign wd_disable_instr = (op == 2'h2);
  assign power_down_instr = (op == 2'h3);
  // Open-drain pin with pull-up
  assign reset_pin = reset_pin_oe ? reset_pin_out : 1'h1;

  // Low pin resets the watchdog through nrst next cycle
  always_ff @(posedge core_clk or negedge bench_rst_n) begin
    if (!bench_rst_n) pin_reg <= 1'h1;
    else pin_reg <= reset_pin;
  end
  assign nrst = bench_rst_n & pin_reg;
endmodule

// >>> tb/instruction_clock_watchdog_tb.sv
// Bench for the watchdog, short counter, CPU model on the far side.
// Assumes the design and its package are compiled first.
`timescale 1ns/1ps

module instruction_clock_watchdog_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic       core_clk = 1'h0;
  logic       bench_rst_n = 1'h0;
  logic       go = 1'h0;
  logic [1:0] op = 2'h0;
  logic       backup_entry = 1'h0;
  logic       nrst, instr_tick, wd_restart_instr, wd_disable_instr, power_down_instr;
  logic       skip_next, wd_reset, reset_pin_out, reset_pin_oe, reset_pin;
  logic       wd_enable_flag, wd_warning_flag, wd_fault_flag;
  logic [7:0] wd_down_counter;
  int         fails = 0;
  int         comparisons = 0;

  always #20 core_clk = ~core_clk;

  icwdt_cpu_model icwdt_cpu_model_inst (.core_clk(core_clk), .bench_rst_n(bench_rst_n),
    .go(go), .op(op), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .instr_tick(instr_tick), .wd_restart_instr(wd_restart_instr),
    .wd_disable_instr(wd_disable_instr), .power_down_instr(power_down_instr),
    .reset_pin(reset_pin), .nrst(nrst));

  icwdt_watchdog #(.CNT_W(8)) icwdt_watchdog_inst (.core_clk(core_clk), .nrst(nrst),
    .instr_tick(instr_tick), .wd_restart_instr(wd_restart_instr),
    .wd_disable_instr(wd_disable_instr), .power_down_instr(power_down_instr),
    .backup_entry(backup_entry), .skip_next(skip_next), .wd_reset(wd_reset),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .wd_enable_flag(wd_enable_flag), .wd_warning_flag(wd_warning_flag),
    .wd_fault_flag(wd_fault_flag), .wd_down_counter(wd_down_counter));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // n back-to-back ticks of one instruction, results settled on return
  task automatic run(input logic [1:0] o, input int n);
    @(posedge core_clk);
    go <= 1'h1;
    op <= o;
    repeat (n) @(posedge core_clk);
    go <= 1'h0;
    #1;
  endtask

  task automatic test_done;
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_count;
    chk(16'(wd_down_counter), 16'h00FF);
    chk(16'(wd_enable_flag), 16'h0001);
    chk(16'({wd_warning_flag, wd_fault_flag, reset_pin_oe}), 16'h0000);
    run(2'h0, 5);
    chk(16'(wd_down_counter), 16'h00FA);
    run(2'h0, 250);
    chk(16'({wd_down_counter, wd_warning_flag}), 16'h0000);
    run(2'h0, 1);
    chk(16'({wd_down_counter, wd_warning_flag}), 16'h01FF);
  endtask

  task automatic t_restart;
    run(2'h1, 1);
    chk(16'({skip_next, wd_warning_flag}), 16'h0002);
    run(2'h1, 1);
    chk(16'(skip_next), 16'h0000);
  endtask

  task automatic t_disable;
    run(2'h2, 1);
    run(2'h0, 1);
    run(2'h1, 1);
    chk(16'(wd_enable_flag), 16'h0001);
    run(2'h2, 1);
    run(2'h1, 1);
    chk(16'(wd_enable_flag), 16'h0000);
  endtask

  task automatic t_off;
    run(2'h0, 512);
    chk(16'({wd_warning_flag, wd_fault_flag, reset_pin_oe}), 16'h0004);
    run(2'h1, 1);
    chk(16'({skip_next, wd_warning_flag}), 16'h0002);
    @(posedge core_clk);
    backup_entry <= 1'h1;
    @(posedge core_clk);
    backup_entry <= 1'h0;
    #1;
    chk(16'(wd_enable_flag), 16'h0001);
  endtask

  task automatic t_pdown;
    run(2'h2, 1);
    run(2'h1, 1);
    chk(16'(wd_enable_flag), 16'h0000);
    run(2'h0, 256);
    chk(16'(wd_warning_flag), 16'h0001);
    run(2'h1, 1);
    chk(16'({skip_next, wd_warning_flag}), 16'h0002);
    run(2'h3, 1);
    chk(16'({wd_down_counter, wd_warning_flag}), 16'h01FE);
    chk(16'(wd_enable_flag), 16'h0001);
  endtask

  task automatic t_fault;
    run(2'h0, 511);
    chk(16'({wd_warning_flag, wd_fault_flag}), 16'h0002);
    run(2'h0, 1);
    chk(16'({wd_fault_flag, wd_reset, reset_pin_oe, reset_pin}), 16'h000E);
    @(posedge core_clk);
    #1;
    chk(16'({wd_fault_flag, wd_enable_flag, wd_down_counter}), 16'h01FF);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    bench_rst_n <= 1'h1;
    #1;
    t_count();
    t_restart();
    t_disable();
    t_off();
    t_pdown();
    t_fault();
    test_done();
  end

  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule
